// >>> core/adc_regs.sv
/*
  Register block of a 10-bit successive approximation converter: result, compare,
  configuration and analog pin disable registers behind an AXI4-Lite slave.
  Assumes the converter core shares MCLK and pulses CONV_DONE for one cycle per result.
*/
// What this block does
// - the low result register gets the low eight bits of a ten-bit result, or the whole eight-bit result.
// - results are stored at each completion unless the interlock holds or compare is on and its condition fails.
// - in ten-bit resolution a high result read blocks new results until the low result is read or the resolution field changes.
// - a result that completes while that block holds is thrown away.
// - in eight-bit resolution result reads never block and results transfer unless compare is on and its condition fails.
// - a change of the resolution field marks the low result invalid until the next stored result.
// - the high compare register gives the top two compare bits, used only in ten-bit resolution.
// - the low compare register's eight bits are compared with the low eight result bits in both resolutions.
// - configuration bit 7 picks high speed at 0 and low power at 1.
// - configuration bits 6:5 divide the chosen clock by 1, 2, 4 or 8.
// - configuration bit 4 picks short sample at 0 and long sample at 1.
// - configuration bits 3:2 pick eight-bit at 00 and ten-bit at 10, the others reserved.
// - configuration bits 1:0 pick bus clock, half bus clock, alternate clock or internal clock.
// - pin disable bit n takes port control away from analog channel n pin for channels 0 to 7.
// - a disabled pin has its driver off, its input reading zero and its pullup off.
// - the compare is met on result at or above the value with greater select set, else below it.
`timescale 1ns/1ps
`default_nettype none
module adc_regs #(
  parameter int PIN_COUNT = 8
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // AXI4-Lite write address and data
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // converter core
  input wire logic CONV_DONE,
  input wire logic [9:0] CONV_DATA,
  output logic CONV_CLK_EN,
  output logic LOW_POWER,
  output logic LONG_SAMPLE,
  output logic [1:0] RESOLUTION,
  // clock source pins
  input wire logic ALT_CLK,
  input wire logic ASYNC_CLK,
  // analog pin control
  input wire logic [PIN_COUNT-1:0] PORT_PIN_IN,
  output logic [PIN_COUNT-1:0] PORT_READ,
  output logic [PIN_COUNT-1:0] PIN_OUTPUT_OFF,
  output logic [PIN_COUNT-1:0] PIN_INPUT_OFF,
  output logic [PIN_COUNT-1:0] PIN_PULLUP_OFF
);

  adc_regs_pkg::regs_s q_q, q_d;
  convclk_if ck ();

  logic ten;
  logic cmp_en;
  logic cmp_gt;
  logic [9:0] conv_val;
  logic [9:0] cmp_ref;
  logic met;
  logic store;
  logic ar_take;
  logic wr_do;
  logic mode_chg;

  // ********************
  // converter clock
  // ********************
  // source and divide straight from the configuration register
  assign ck.src = q_q.cfg[adc_regs_pkg::CFG_SRC_LSB +: 2];
  assign ck.div = q_q.cfg[adc_regs_pkg::CFG_DIV_LSB +: 2];

  convclk_gen u_clkgen (
    .clk(MCLK),
    .rst(RST),
    .alt_clk_pin(ALT_CLK),
    .async_clk_pin(ASYNC_CLK),
    .ck(ck.gen)
  );

  // ********************
  // compare and store decision
  // ********************
  // reserved resolution codes behave as eight-bit
  assign ten = q_q.cfg[adc_regs_pkg::CFG_RES_LSB +: 2] == adc_regs_pkg::RES_TEN;
  assign cmp_en = q_q.cmp_ctl[adc_regs_pkg::CMP_ENABLE_BIT];
  assign cmp_gt = q_q.cmp_ctl[adc_regs_pkg::CMP_GREATER_BIT];
  assign conv_val = ten ? CONV_DATA : {2'h0, CONV_DATA[7:0]};
  assign cmp_ref = ten ? {q_q.cmp_high[1:0], q_q.cmp_low} : {2'h0, q_q.cmp_low};
  assign met = cmp_gt ? (conv_val >= cmp_ref) : (conv_val < cmp_ref);
  // the interlock only ever sets in ten-bit, so eight-bit results always pass it
  assign store = CONV_DONE && !q_q.lock && (!cmp_en || met);
  assign ar_take = q_q.arready && ARVALID;
  assign wr_do = q_q.aw_got && q_q.w_got && !q_q.bvalid;
  assign mode_chg = wr_do && q_q.wlane0 && q_q.awaddr == adc_regs_pkg::OFF_CONFIG
    && q_q.wdata[adc_regs_pkg::CFG_RES_LSB +: 2] != q_q.cfg[adc_regs_pkg::CFG_RES_LSB +: 2];

  // ********************
  // next state
  // ********************
  always_comb begin
    q_d = q_q;
    // pin inputs pass two flops before the gate that forces zero on disabled pins
    q_d.port_s1 = PORT_PIN_IN;
    q_d.port_s2 = q_q.port_s1;
    q_d.port_rd = q_q.port_s2 & ~q_q.pin_dis;

    // write address and data are taken in either order
    if (q_q.awready && AWVALID) begin
      q_d.aw_got = 1'b1;
      q_d.awaddr = AWADDR;
    end
    if (q_q.wready && WVALID) begin
      q_d.w_got = 1'b1;
      q_d.wdata = WDATA[7:0];
      q_d.wlane0 = WSTRB[0];
    end
    if (q_q.bvalid && BREADY) begin
      q_d.bvalid = 1'b0;
    end

    // write decode; registers sit in byte lane 0
    if (wr_do) begin
      q_d.aw_got = 1'b0;
      q_d.w_got = 1'b0;
      q_d.bvalid = 1'b1;
      q_d.bresp = adc_regs_pkg::RESP_OKAY;
      case (q_q.awaddr)
        adc_regs_pkg::OFF_CMP_HIGH: if (q_q.wlane0) q_d.cmp_high = {6'h00, q_q.wdata[1:0]};
        adc_regs_pkg::OFF_CMP_LOW: if (q_q.wlane0) q_d.cmp_low = q_q.wdata;
        adc_regs_pkg::OFF_CONFIG: if (q_q.wlane0) q_d.cfg = q_q.wdata;
        adc_regs_pkg::OFF_PIN_DISABLE: if (q_q.wlane0) q_d.pin_dis = q_q.wdata;
        adc_regs_pkg::OFF_CMP_CONTROL: if (q_q.wlane0) q_d.cmp_ctl = {6'h00, q_q.wdata[1:0]};
        adc_regs_pkg::OFF_RESULT_HIGH, adc_regs_pkg::OFF_RESULT_LOW, adc_regs_pkg::OFF_STATUS: begin
          // read-only: the write is answered and dropped
        end
        default: q_d.bresp = adc_regs_pkg::RESP_SLVERR;
      endcase
    end
    // a resolution change voids the held result and releases the interlock
    if (mode_chg) begin
      q_d.valid = 1'b0;
      q_d.lock = 1'b0;
    end

    // read: data is latched on the address edge, so reads have their side effects at once
    if (q_q.rvalid && RREADY) begin
      q_d.rvalid = 1'b0;
    end
    if (ar_take) begin
      q_d.rvalid = 1'b1;
      q_d.rresp = adc_regs_pkg::RESP_OKAY;
      q_d.rdata = 32'h0000_0000;
      case (ARADDR)
        adc_regs_pkg::OFF_RESULT_HIGH: begin
          q_d.rdata[1:0] = q_q.result[9:8];
          if (ten && !mode_chg) q_d.lock = 1'b1;
        end
        adc_regs_pkg::OFF_RESULT_LOW: begin
          q_d.rdata[7:0] = q_q.result[7:0];
          q_d.lock = 1'b0;
        end
        adc_regs_pkg::OFF_CMP_HIGH: q_d.rdata[7:0] = q_q.cmp_high;
        adc_regs_pkg::OFF_CMP_LOW: q_d.rdata[7:0] = q_q.cmp_low;
        adc_regs_pkg::OFF_CONFIG: q_d.rdata[7:0] = q_q.cfg;
        adc_regs_pkg::OFF_PIN_DISABLE: q_d.rdata[7:0] = q_q.pin_dis;
        adc_regs_pkg::OFF_CMP_CONTROL: q_d.rdata[7:0] = q_q.cmp_ctl;
        adc_regs_pkg::OFF_STATUS: begin
          q_d.rdata[adc_regs_pkg::STAT_VALID_BIT] = q_q.valid;
          q_d.rdata[adc_regs_pkg::STAT_LOCK_BIT] = q_q.lock;
        end
        default: q_d.rresp = adc_regs_pkg::RESP_SLVERR;
      endcase
    end

    // a stored result wins over the invalidation of the same cycle
    if (store) begin
      q_d.result = conv_val;
      q_d.valid = 1'b1;
    end

    // one transfer of each kind at a time
    q_d.awready = !q_d.aw_got && !q_d.bvalid;
    q_d.wready = !q_d.w_got && !q_d.bvalid;
    q_d.arready = !q_d.rvalid;
  end

  // ********************
  // state register
  // ********************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      q_q <= '0;
      q_q.cfg <= adc_regs_pkg::CONFIG_RESET;
      q_q.cmp_high <= adc_regs_pkg::CMP_RESET;
      q_q.cmp_low <= adc_regs_pkg::CMP_RESET;
      q_q.pin_dis <= adc_regs_pkg::PIN_DISABLE_RESET;
    end else begin
      q_q <= q_d;
    end
  end

  // ********************
  // outputs
  // ********************
  assign AWREADY = q_q.awready;
  assign WREADY = q_q.wready;
  assign BVALID = q_q.bvalid;
  assign BRESP = q_q.bresp;
  assign ARREADY = q_q.arready;
  assign RVALID = q_q.rvalid;
  assign RDATA = q_q.rdata;
  assign RRESP = q_q.rresp;
  assign CONV_CLK_EN = ck.tick;
  assign LOW_POWER = q_q.cfg[adc_regs_pkg::CFG_LOW_POWER_BIT];
  assign LONG_SAMPLE = q_q.cfg[adc_regs_pkg::CFG_LONG_SAMPLE_BIT];
  assign RESOLUTION = q_q.cfg[adc_regs_pkg::CFG_RES_LSB +: 2];
  assign PORT_READ = q_q.port_rd;

  // one flop feeds all three pin overrides, so they can never disagree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      assign PIN_OUTPUT_OFF[gi] = q_q.pin_dis[gi];
      assign PIN_INPUT_OFF[gi] = q_q.pin_dis[gi];
      assign PIN_PULLUP_OFF[gi] = q_q.pin_dis[gi];
    end
  endgenerate

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_high_read_ten;
    ar_take && ARADDR == adc_regs_pkg::OFF_RESULT_HIGH && ten && !mode_chg;
  endsequence
  sequence s_low_read;
    ar_take && ARADDR == adc_regs_pkg::OFF_RESULT_LOW;
  endsequence
  sequence s_cfg_write;
    wr_do && q_q.wlane0 && q_q.awaddr == adc_regs_pkg::OFF_CONFIG;
  endsequence

  property p_store_low;
    store |=> q_q.result[7:0] == $past(CONV_DATA[7:0]) && q_q.valid;
  endproperty
  a_store_low: assert property (p_store_low) else $error("stored result low bits wrong");

  property p_cmp_hold;
    CONV_DONE && cmp_en && !met |=> $stable(q_q.result);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("result changed on failed compare");

  property p_lock_set;
    s_high_read_ten ##1 !mode_chg |-> q_q.lock ##1 q_q.lock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("interlock not held after high read");

  property p_lock_drop;
    CONV_DONE && q_q.lock |=> $stable(q_q.result);
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("result stored while interlocked");

  property p_eight_free;
    !ten |-> !q_q.lock;
  endproperty
  a_eight_free: assert property (p_eight_free) else $error("interlock held in eight-bit");

  property p_mode_invalid;
    mode_chg && !store |=> !q_q.valid;
  endproperty
  a_mode_invalid: assert property (p_mode_invalid) else $error("result still valid after resolution change");

  property p_eight_ref;
    !ten |-> cmp_ref[9:8] == 2'h0 && conv_val[9:8] == 2'h0;
  endproperty
  a_eight_ref: assert property (p_eight_ref) else $error("upper compare bits used in eight-bit");

  property p_greater;
    CONV_DONE && !q_q.lock && cmp_en && cmp_gt && conv_val >= cmp_ref |=> q_q.result == $past(conv_val);
  endproperty
  a_greater: assert property (p_greater) else $error("greater-or-equal compare not stored");

  property p_pin_zero;
    q_q.pin_dis != 8'h00 |=> (q_q.port_rd & $past(q_q.pin_dis)) == 8'h00;
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("disabled pin read not zero");

  property p_low_clear;
    s_low_read |=> !q_q.lock;
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("interlock held after low read");

  property p_less;
    CONV_DONE && !q_q.lock && cmp_en && !cmp_gt && conv_val < cmp_ref |=> q_q.result == $past(conv_val);
  endproperty
  a_less: assert property (p_less) else $error("less-than compare not stored");

  // configuration fields reach their outputs one edge after the write
  property p_cfg_power;
    s_cfg_write |=> LOW_POWER == $past(q_q.wdata[adc_regs_pkg::CFG_LOW_POWER_BIT]);
  endproperty
  a_cfg_power: assert property (p_cfg_power) else $error("power select not applied");

  property p_cfg_div;
    s_cfg_write |=> ck.div == $past(q_q.wdata[adc_regs_pkg::CFG_DIV_LSB +: 2]);
  endproperty
  a_cfg_div: assert property (p_cfg_div) else $error("clock divide not applied");

  property p_cfg_sample;
    s_cfg_write |=> LONG_SAMPLE == $past(q_q.wdata[adc_regs_pkg::CFG_LONG_SAMPLE_BIT]);
  endproperty
  a_cfg_sample: assert property (p_cfg_sample) else $error("sample select not applied");

  property p_cfg_res;
    s_cfg_write |=> RESOLUTION == $past(q_q.wdata[adc_regs_pkg::CFG_RES_LSB +: 2]);
  endproperty
  a_cfg_res: assert property (p_cfg_res) else $error("resolution not applied");

  property p_cfg_src;
    s_cfg_write |=> ck.src == $past(q_q.wdata[adc_regs_pkg::CFG_SRC_LSB +: 2]);
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("clock source not applied");

  property p_pin_write;
    wr_do && q_q.wlane0 && q_q.awaddr == adc_regs_pkg::OFF_PIN_DISABLE |=> PIN_OUTPUT_OFF == $past(q_q.wdata);
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("pin disable not applied");

endmodule // adc_regs
`default_nettype wire

// >>> core/adc_regs_pkg.sv
/*
  Constants and state types for the converter register block.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses in the low eight address bits.
*/
`default_nettype none
package adc_regs_pkg;

  // ********************
  // register byte offsets
  // ********************
  localparam logic [7:0] OFF_RESULT_HIGH = 8'h00;
  localparam logic [7:0] OFF_RESULT_LOW = 8'h04;
  localparam logic [7:0] OFF_CMP_HIGH = 8'h08;
  localparam logic [7:0] OFF_CMP_LOW = 8'h0C;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam logic [7:0] OFF_PIN_DISABLE = 8'h14;
  localparam logic [7:0] OFF_CMP_CONTROL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ********************
  // field positions and encodings
  // ********************
  localparam int CFG_LOW_POWER_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_LONG_SAMPLE_BIT = 4;
  localparam int CFG_RES_LSB = 2;
  localparam int CFG_SRC_LSB = 0;
  localparam int CMP_ENABLE_BIT = 0;
  localparam int CMP_GREATER_BIT = 1;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam logic [1:0] RES_EIGHT = 2'h0;
  localparam logic [1:0] RES_TEN = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS_HALF = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************
  // values after reset
  // ********************
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;

  // state of the register block
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wlane0;
    logic [9:0] result;
    logic valid;
    logic lock;
    logic [7:0] cmp_high;
    logic [7:0] cmp_low;
    logic [7:0] cfg;
    logic [7:0] pin_dis;
    logic [7:0] cmp_ctl;
    logic [7:0] port_s1;
    logic [7:0] port_s2;
    logic [7:0] port_rd;
  } regs_s;

  // state of the converter clock generator
  typedef struct packed {
    logic alt_s1;
    logic alt_s2;
    logic alt_s3;
    logic asy_s1;
    logic asy_s2;
    logic asy_s3;
    logic half;
    logic [2:0] cnt;
    logic tick;
  } clkgen_s;

endpackage
`default_nettype wire

// >>> core/convclk_gen.sv
/*
  Converter clock generator: picks a source and divides it into a one-cycle enable.
  Assumes alternate and internal oscillator clocks arrive as pins slower than half the bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
module convclk_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // clock source pins
  input wire logic alt_clk_pin,
  input wire logic async_clk_pin,
  // configuration and enable out
  convclk_if.gen ck
);

  adc_regs_pkg::clkgen_s q_q, q_d;
  logic src_tick;
  logic [2:0] lim;

  // ********************
  // source select and divide
  // ********************
  // outside clocks are sampled, so their rising edges become bus-clock ticks
  always_comb begin
    q_d = q_q;
    q_d.alt_s1 = alt_clk_pin;
    q_d.alt_s2 = q_q.alt_s1;
    q_d.alt_s3 = q_q.alt_s2;
    q_d.asy_s1 = async_clk_pin;
    q_d.asy_s2 = q_q.asy_s1;
    q_d.asy_s3 = q_q.asy_s2;
    q_d.half = ~q_q.half;
    case (ck.src)
      adc_regs_pkg::SRC_BUS: src_tick = 1'b1;
      adc_regs_pkg::SRC_BUS_HALF: src_tick = q_q.half;
      adc_regs_pkg::SRC_ALT: src_tick = q_q.alt_s2 & ~q_q.alt_s3;
      default: src_tick = q_q.asy_s2 & ~q_q.asy_s3;
    endcase
    case (ck.div)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      default: lim = 3'h7;
    endcase
    q_d.tick = 1'b0;
    if (src_tick) begin
      if (q_q.cnt >= lim) begin
        q_d.cnt = 3'h0;
        q_d.tick = 1'b1;
      end else begin
        q_d.cnt = q_q.cnt + 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign ck.tick = q_q.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // from bus clock divided by two or more there is never a tick on two neighbouring edges
  property p_tick_gap;
    q_q.tick && ck.src == adc_regs_pkg::SRC_BUS && ck.div != 2'h0 && $stable(ck.div) |=> !q_q.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("divided tick came back to back");

endmodule // convclk_gen
`default_nettype wire

// >>> core/convclk_if.sv
/*
  Carrier between the register block and its converter clock generator.
  Assumes both ends run on the bus clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface convclk_if;
  logic [1:0] src;
  logic [1:0] div;
  logic tick;
  modport cfg (output src, output div, input tick);
  modport gen (input src, input div, output tick);
endinterface
`default_nettype wire

// >>> test/conv_core_model.sv
/*
  Behavioural model of the converter core behind the register block.
  Assumes the bench pulses start for one cycle and tick is the block's clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the bench
  input wire logic start,
  input wire logic [9:0] value,
  input wire logic tick,
  // result towards the block
  output logic busy,
  output logic done,
  output logic [9:0] data
);
  logic [1:0] left_q;
  logic [9:0] held_q;
  // three converter clock ticks per conversion, then a one-cycle done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      left_q <= 2'h0;
      held_q <= 10'h000;
      data <= 10'h3FF;
    end else begin
      done <= 1'b0;
      data <= ~data; // stale data toggles so the block cannot trust it off the pulse
      if (start && !busy) begin
        busy <= 1'b1;
        left_q <= 2'h2;
        held_q <= value;
      end else if (busy && tick) begin
        if (left_q == 2'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
          data <= held_q;
        end else begin
          left_q <= left_q - 2'h1;
        end
      end
    end
  end
endmodule // conv_core_model
`default_nettype wire

// >>> test/tb_top.sv
/*
  Self-checking bench for the converter register block.
  Assumes the converter model and the package offsets; bus is driven at rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ********************
  // signals
  // ********************
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, ALT_CLK, ASYNC_CLK, start;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_DONE, CONV_CLK_EN, LOW_POWER, LONG_SAMPLE, busy;
  logic [7:0] AWADDR, ARADDR, PORT_PIN_IN, PORT_READ, PIN_OUTPUT_OFF, PIN_INPUT_OFF, PIN_PULLUP_OFF;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, RESOLUTION, resp;
  logic [9:0] CONV_DATA, conv_val;
  logic [31:0] rdv;
  int err_total, comparisons, cycles, pin_cnt;
  adc_regs dut (.MCLK, .RST, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
    .CONV_DONE, .CONV_DATA, .CONV_CLK_EN, .LOW_POWER, .LONG_SAMPLE, .RESOLUTION, .ALT_CLK,
    .ASYNC_CLK, .PORT_PIN_IN, .PORT_READ, .PIN_OUTPUT_OFF, .PIN_INPUT_OFF, .PIN_PULLUP_OFF);
  conv_core_model core (.clk(MCLK), .rst(RST), .start(start), .value(conv_val), .tick(CONV_CLK_EN),
    .busy(busy), .done(CONV_DONE), .data(CONV_DATA));
  // clock, and slow source pins: alternate every 16 cycles, internal every 8
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  always @(posedge MCLK) begin
    pin_cnt <= pin_cnt + 1;
    if (pin_cnt % 8 == 7) ALT_CLK <= ~ALT_CLK;
    if (pin_cnt % 4 == 3) ASYNC_CLK <= ~ASYNC_CLK;
  end
  // hang guard: the whole run needs a few thousand cycles
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      final_report();
    end
  end
  // ********************
  // shared tasks
  // ********************
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
    logic aw, w, b;
    AWADDR <= a;
    WDATA <= {24'h000000, d};
    WSTRB <= {3'h0, s};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge MCLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      b = BVALID;
      resp = BRESP;
      @(posedge MCLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (b) BREADY <= 1'b0;
    end
    @(posedge MCLK);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge MCLK);
      ar = ARVALID && ARREADY;
      r = RVALID;
      rdv = RDATA;
      resp = RRESP;
      @(posedge MCLK);
      if (ar) ARVALID <= 1'b0;
      if (r) RREADY <= 1'b0;
    end
    @(posedge MCLK);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(what, rdv, e);
  endtask
  // one conversion through the model; returns after the block has seen done
  task automatic conv(input logic [9:0] v);
    start <= 1'b1;
    conv_val <= v;
    @(posedge MCLK);
    start <= 1'b0;
    do @(negedge MCLK); while (busy);
    @(posedge MCLK);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset();
    rchk("cfg", adc_regs_pkg::OFF_CONFIG, {24'h0, adc_regs_pkg::CONFIG_RESET});
    rchk("cvh", adc_regs_pkg::OFF_CMP_HIGH, {24'h0, adc_regs_pkg::CMP_RESET});
    rchk("cvl", adc_regs_pkg::OFF_CMP_LOW, {24'h0, adc_regs_pkg::CMP_RESET});
    rchk("pin", adc_regs_pkg::OFF_PIN_DISABLE, {24'h0, adc_regs_pkg::PIN_DISABLE_RESET});
    rchk("unmapped", 8'h20, 32'h0);
    chk("unmapped rresp", resp, adc_regs_pkg::RESP_SLVERR);
    wr(8'h20, 8'h55, 1'b1);
    chk("unmapped bresp", resp, adc_regs_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_eight();
    conv(10'h2A5);
    rchk("rh8", adc_regs_pkg::OFF_RESULT_HIGH, 32'h0);
    rchk("rl8", adc_regs_pkg::OFF_RESULT_LOW, 32'hA5);
    rd(adc_regs_pkg::OFF_RESULT_HIGH);
    conv(10'h15A);
    rchk("rl8 no lock", adc_regs_pkg::OFF_RESULT_LOW, 32'h5A);
    wr(adc_regs_pkg::OFF_RESULT_LOW, 8'hFF, 1'b1);
    rchk("rl ro", adc_regs_pkg::OFF_RESULT_LOW, 32'h5A);
    wr(adc_regs_pkg::OFF_CMP_LOW, 8'h77, 1'b0);
    rchk("strobe off", adc_regs_pkg::OFF_CMP_LOW, 32'h0);
    $display("test eight-bit done");
  endtask
  task automatic t_ten();
    wr(adc_regs_pkg::OFF_CONFIG, 8'h08, 1'b1);
    chk("res out", RESOLUTION, adc_regs_pkg::RES_TEN);
    conv(10'h2A5);
    rchk("rh10", adc_regs_pkg::OFF_RESULT_HIGH, 32'h2);
    conv(10'h111);
    rchk("rl held", adc_regs_pkg::OFF_RESULT_LOW, 32'hA5);
    conv(10'h1C3);
    rchk("rh new", adc_regs_pkg::OFF_RESULT_HIGH, 32'h1);
    rchk("rl new", adc_regs_pkg::OFF_RESULT_LOW, 32'hC3);
    rchk("valid", adc_regs_pkg::OFF_STATUS, 32'h1);
    $display("test ten-bit done");
  endtask
  task automatic t_cmp();
    wr(adc_regs_pkg::OFF_CMP_HIGH, 8'h01, 1'b1);
    wr(adc_regs_pkg::OFF_CMP_LOW, 8'h00, 1'b1);
    wr(adc_regs_pkg::OFF_CMP_CONTROL, 8'h03, 1'b1);
    conv(10'h0FF);
    rchk("ge miss", adc_regs_pkg::OFF_RESULT_LOW, 32'hC3);
    conv(10'h100);
    rchk("ge hit", adc_regs_pkg::OFF_RESULT_LOW, 32'h00);
    wr(adc_regs_pkg::OFF_CMP_CONTROL, 8'h01, 1'b1);
    conv(10'h180);
    rchk("lt miss", adc_regs_pkg::OFF_RESULT_LOW, 32'h00);
    conv(10'h0FE);
    rchk("lt hit", adc_regs_pkg::OFF_RESULT_LOW, 32'hFE);
    wr(adc_regs_pkg::OFF_CONFIG, 8'h00, 1'b1);
    rchk("invalid", adc_regs_pkg::OFF_STATUS, 32'h0);
    wr(adc_regs_pkg::OFF_CMP_LOW, 8'h10, 1'b1);
    wr(adc_regs_pkg::OFF_CMP_CONTROL, 8'h03, 1'b1);
    conv(10'h020);
    rchk("cvh unused", adc_regs_pkg::OFF_RESULT_LOW, 32'h20);
    conv(10'h00F);
    rchk("cvl used", adc_regs_pkg::OFF_RESULT_LOW, 32'h20);
    wr(adc_regs_pkg::OFF_CMP_CONTROL, 8'h00, 1'b1);
    $display("test compare done");
  endtask
  task automatic t_cfg_pins();
    wr(adc_regs_pkg::OFF_CONFIG, 8'hF8, 1'b1);
    chk("low power", LOW_POWER, 1'b1);
    chk("long sample", LONG_SAMPLE, 1'b1);
    rchk("cfg rb", adc_regs_pkg::OFF_CONFIG, 32'hF8);
    wr(adc_regs_pkg::OFF_CONFIG, 8'h04, 1'b1);
    chk("reserved res", RESOLUTION, 2'h1);
    chk("short fast", {LOW_POWER, LONG_SAMPLE}, 2'h0);
    PORT_PIN_IN <= 8'hFF;
    wr(adc_regs_pkg::OFF_PIN_DISABLE, 8'h0F, 1'b1);
    repeat (4) @(posedge MCLK);
    chk("out off", PIN_OUTPUT_OFF, 8'h0F);
    chk("in off", PIN_INPUT_OFF, 8'h0F);
    chk("pull off", PIN_PULLUP_OFF, 8'h0F);
    chk("port read", PORT_READ, 8'hF0);
    $display("test config and pins done");
  endtask
  // enable pulses in 64 cycles per source and divide, within one pulse
  task automatic t_clock();
    int n, e;
    int per[4] = '{1, 2, 16, 8};
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr(adc_regs_pkg::OFF_CONFIG, {1'b0, d[1:0], 3'h0, s[1:0]}, 1'b1);
        repeat (40) @(posedge MCLK);
        n = 0;
        e = 64 / (per[s] * (1 << d));
        repeat (64) begin
          @(negedge MCLK);
          n = n + int'(CONV_CLK_EN);
        end
        chk("tick count", (n + 1 >= e) && (n <= e + 1), 1'b1);
      end
    end
    $display("test clock done");
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, ALT_CLK, ASYNC_CLK, start} = 8'h00;
    {AWADDR, ARADDR, PORT_PIN_IN, WSTRB, WDATA} = 60'h0;
    conv_val = 10'h000;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    pin_cnt = 0;
    RST = 1'b1;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    t_reset();
    t_eight();
    t_ten();
    t_cmp();
    t_cfg_pins();
    t_clock();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
